// ---- hdl/card_video_map.svh ----
`ifndef CARD_VIDEO_MAP_SVH
`define CARD_VIDEO_MAP_SVH

// Configuration space offsets, one byte each.
`define CVP_CFG_CARD_CTRL 8'h91
`define CVP_CFG_DIAG 8'h93

// Socket register space byte offsets.
`define CVP_SK_PRESENT 8'h08
`define CVP_SK_FORCE 8'h0C
`define CVP_SK_CTRL 8'h10

// Field positions.
`define CVP_LEGACY_EN_BIT 6
`define CVP_DIAG_DIS_BIT 0
`define CVP_CAPABLE_BIT 27
`define CVP_FORCE_CAP_BIT 27
`define CVP_ACTIVITY_BIT 11
`define CVP_STD_PRESENT_BIT 10
`define CVP_SOCK_EN_BIT 9
`define CVP_CARDBUS_BIT 4
`define CVP_VALID_BIT 5
`define CVP_VOLT_LSB 6

// Reset values.
`define CVP_RST_BYTE 8'h00
`define CVP_RST_WORD 32'h0000_0000

// Timing: low-rate oscillator period and the system clock period.
`define CVP_OSC_PERIOD_NS 62500
`define CVP_CLK_PERIOD_NS 8
`define CVP_OSC_DIV_CYCLES (`CVP_OSC_PERIOD_NS / `CVP_CLK_PERIOD_NS)
`define CVP_SETTLE_TICKS 2'h2

`endif

// ---- hdl/card_video_pkg.sv ----
package card_video_pkg;

  // Card detection progress of one socket.
  typedef enum logic [1:0] {DET_EMPTY, DET_SETTLE, DET_READY} det_state_e;

  // Result of interrogating one socket.
  typedef struct packed {
    logic present;
    logic cardbus;
    logic [1:0] volt;
    logic pull_up;
    logic pull_dn;
  } detect_s;

endpackage

// ---- hdl/card_detect_if.sv ----
`timescale 1ns/1ps
interface card_detect_if;
  logic tick;
  logic card_detect_one;
  logic card_detect_two;
  logic volt_sense_one;
  logic volt_sense_two;
  logic powered;
  card_video_pkg::detect_s result;

  modport unit (input tick, input card_detect_one, input card_detect_two,
    input volt_sense_one, input volt_sense_two, input powered,
    output result);
  modport ctrl (output tick, output card_detect_one, output card_detect_two,
    output volt_sense_one, output volt_sense_two,
    output powered, input result);
endinterface

// ---- hdl/card_detect_unit.sv ----
`timescale 1ns/1ps
`include "card_video_map.svh"
module card_detect_unit (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Socket pins and detection result.
  card_detect_if.unit port
);
  import card_video_pkg::*;

  typedef struct packed {
    det_state_e st;
    logic [1:0] cnt;
    detect_s res;
  } unit_s;

  unit_s r;
  unit_s next_r;
  logic inserted;

  // A card pulls at least one detect line low once it is seated.
  assign inserted = !port.card_detect_one || !port.card_detect_two;

  // Detection waits a few slow ticks so contact bounce settles first.
  always_comb begin
    next_r = r;
    case (r.st)
      DET_EMPTY: begin
        next_r.cnt = 2'h0;
        if (inserted) begin
          next_r.st = DET_SETTLE;
        end
      end
      DET_SETTLE: begin
        if (!inserted) begin
          next_r.st = DET_EMPTY;
        end else if (port.tick) begin
          next_r.cnt = r.cnt + 2'h1;
          // Interrogation only runs in a cold socket.
          if (r.cnt + 2'h1 >= `CVP_SETTLE_TICKS && !port.powered) begin
            next_r.st = DET_READY;
            next_r.res.present = 1'b1;
            next_r.res.cardbus = port.card_detect_one != port.card_detect_two;
            next_r.res.volt = {port.volt_sense_two, port.volt_sense_one};
            next_r.res.pull_up = port.card_detect_one == port.card_detect_two;
            next_r.res.pull_dn = port.card_detect_one != port.card_detect_two;
          end
        end
      end
      DET_READY: begin
        if (!inserted) begin
          next_r.st = DET_EMPTY;
          next_r.res = '0;
        end
      end
      default: begin
        next_r.st = DET_EMPTY;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign port.result = r.res;

  a_pull_exclusive: assert property (@(posedge clk) disable iff (!resetn)
    r.res.present |-> (r.res.pull_up ^ r.res.pull_dn))
    else $error("Status-change pull not exclusive.");

  a_empty_clears: assert property (@(posedge clk) disable iff (!resetn)
    (r.st == DET_READY && !inserted) |=> !r.res.present)
    else $error("Removed card still reported present.");
endmodule

// ---- hdl/card_video_port_control.sv ----
// Function
// - Legacy control bit six enables video mode.
// - Video mode releases upper card address lines.
// - Lower four address lines stay driven.
// - Video select output is active low.
// - Disabled socket drives select high.
// - Port choice one forces status high.
// - Read-only platform capability bit 27.
// - Force register bit 27 sets capability.
// - Activity bit shows any socket in video.
// - Report standardized register model support.
// - Writable per-socket video enable bit nine.
// - Diagnostic bit zero disables standardized model.
// - Either enable path works when allowed.
// - Free-running nominal 16 kHz slow clock.
// - Status-change pull follows card type.
// - Interrogate detect and sense lines cold.
`timescale 1ns/1ps
`include "card_video_map.svh"
module card_video_port_control #(
  parameter int NSOCK = 2,
  parameter int OSC_DIV = `CVP_OSC_DIV_CYCLES,
  parameter int SW = (NSOCK > 1) ? $clog2(NSOCK) : 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Configuration space access, one byte wide.
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [SW-1:0] cfg_sock,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  // Socket register space access, one word wide.
  input wire logic sk_wr,
  input wire logic sk_rd,
  input wire logic [SW-1:0] sk_sock,
  input wire logic [7:0] sk_addr,
  input wire logic [31:0] sk_wdata,
  output logic [31:0] sk_rdata,
  // Card address path.
  input wire logic [NSOCK-1:0][25:0] host_addr,
  output logic [NSOCK-1:0][25:0] card_addr_out,
  output logic [NSOCK-1:0] card_addr_hi_oe,
  output logic [NSOCK-1:0] card_addr_lo_oe,
  // Video steering to the external bus drivers.
  input wire logic port_choice,
  output logic video_select_n,
  output logic video_status_out,
  // Card detect and sense pins.
  input wire logic [NSOCK-1:0] card_detect_one,
  input wire logic [NSOCK-1:0] card_detect_two,
  input wire logic [NSOCK-1:0] volt_sense_one,
  input wire logic [NSOCK-1:0] volt_sense_two,
  input wire logic [NSOCK-1:0] socket_powered,
  // Status-change terminal pull selection.
  output logic [NSOCK-1:0] status_pull_up_en,
  output logic [NSOCK-1:0] status_pull_down_en
);
  import card_video_pkg::*;

  typedef struct packed {
    logic [NSOCK-1:0] legacy_video_enable;
    logic [NSOCK-1:0] socket_video_on;
    logic [NSOCK-1:0] platform_video_capable;
    logic std_model_disable;
    logic [15:0] osc_cnt;
    logic osc_tick;
    logic [7:0] cfg_rdata;
    logic [31:0] sk_rdata;
    logic [NSOCK-1:0][25:0] addr_out;
    logic [NSOCK-1:0] hi_oe;
    logic [NSOCK-1:0] lo_oe;
    logic sel_n;
    logic stat;
    logic [NSOCK-1:0] pull_up;
    logic [NSOCK-1:0] pull_dn;
  } ctrl_s;

  ctrl_s r;
  ctrl_s next_r;
  logic [NSOCK-1:0] eff;
  logic sel_en;
  detect_s [NSOCK-1:0] det;

  // Register address match, shared by both access spaces.
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = addr == off;
  endfunction

  // One detection unit per socket, all paced by the slow oscillator tick.
  for (genvar s = 0; s < NSOCK; s++) begin : g_det
    card_detect_if dif();
    assign dif.tick = r.osc_tick;
    assign dif.card_detect_one = card_detect_one[s];
    assign dif.card_detect_two = card_detect_two[s];
    assign dif.volt_sense_one = volt_sense_one[s];
    assign dif.volt_sense_two = volt_sense_two[s];
    assign dif.powered = socket_powered[s];
    assign det[s] = dif.result;
    card_detect_unit u_det (
      .clk(clk),
      .resetn(resetn),
      .port(dif.unit)
    );
  end

  // The diagnostic bit silences only the standardized enable; the legacy one always works.
  assign eff = r.legacy_video_enable | (r.socket_video_on & {NSOCK{!r.std_model_disable}});
  // Port choice selects which socket's enable feeds the steering pins.
  assign sel_en = eff[port_choice ? 1 : 0];

  // Next-state logic for registers, oscillator and pins.
  always_comb begin
    next_r = r;
    // Slow tick is free running so detection needs no host clock activity.
    if (r.osc_cnt >= 16'(OSC_DIV - 1)) begin
      next_r.osc_cnt = 16'h0000;
      next_r.osc_tick = 1'b1;
    end else begin
      next_r.osc_cnt = r.osc_cnt + 16'h0001;
      next_r.osc_tick = 1'b0;
    end
    // Configuration writes.
    if (cfg_wr && hit(cfg_addr, `CVP_CFG_CARD_CTRL)) begin
      next_r.legacy_video_enable[cfg_sock] = cfg_wdata[`CVP_LEGACY_EN_BIT];
    end
    if (cfg_wr && hit(cfg_addr, `CVP_CFG_DIAG)) begin
      next_r.std_model_disable = cfg_wdata[`CVP_DIAG_DIS_BIT];
    end
    // Socket writes; the capability bit can only be set, never cleared by software.
    if (sk_wr && hit(sk_addr, `CVP_SK_FORCE) && sk_wdata[`CVP_FORCE_CAP_BIT]) begin
      next_r.platform_video_capable[sk_sock] = 1'b1;
    end
    if (sk_wr && hit(sk_addr, `CVP_SK_CTRL)) begin
      next_r.socket_video_on[sk_sock] = sk_wdata[`CVP_SOCK_EN_BIT];
    end
    // Configuration reads; unmapped offsets read as zero.
    next_r.cfg_rdata = `CVP_RST_BYTE;
    if (cfg_rd && hit(cfg_addr, `CVP_CFG_CARD_CTRL)) begin
      next_r.cfg_rdata[`CVP_LEGACY_EN_BIT] = r.legacy_video_enable[cfg_sock];
    end
    if (cfg_rd && hit(cfg_addr, `CVP_CFG_DIAG)) begin
      next_r.cfg_rdata[`CVP_DIAG_DIS_BIT] = r.std_model_disable;
    end
    // Socket reads; the force register is write only and reads as zero.
    next_r.sk_rdata = `CVP_RST_WORD;
    if (sk_rd && hit(sk_addr, `CVP_SK_PRESENT)) begin
      next_r.sk_rdata[`CVP_CAPABLE_BIT] = r.platform_video_capable[sk_sock];
      next_r.sk_rdata[`CVP_CARDBUS_BIT] = det[sk_sock].cardbus;
      next_r.sk_rdata[`CVP_VALID_BIT] = det[sk_sock].present;
      next_r.sk_rdata[`CVP_VOLT_LSB+1:`CVP_VOLT_LSB] = det[sk_sock].volt;
    end
    if (sk_rd && hit(sk_addr, `CVP_SK_CTRL)) begin
      next_r.sk_rdata[`CVP_ACTIVITY_BIT] = |eff;
      next_r.sk_rdata[`CVP_STD_PRESENT_BIT] = !r.std_model_disable;
      next_r.sk_rdata[`CVP_SOCK_EN_BIT] = r.socket_video_on[sk_sock];
    end
    // Address pins: upper lines float while the card streams video.
    next_r.addr_out = host_addr;
    next_r.hi_oe = ~eff;
    next_r.lo_oe = {NSOCK{1'b1}};
    // Steering pins: select follows the enable, status is low only when both are low.
    next_r.sel_n = !sel_en;
    next_r.stat = port_choice | sel_en;
    for (int s = 0; s < NSOCK; s++) begin
      next_r.pull_up[s] = det[s].pull_up;
      next_r.pull_dn[s] = det[s].pull_dn;
    end
  end

  // State register; address lines come up driven and steering pins inactive.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
      r.hi_oe <= {NSOCK{1'b1}};
      r.lo_oe <= {NSOCK{1'b1}};
      r.sel_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from the state register.
  assign cfg_rdata = r.cfg_rdata;
  assign sk_rdata = r.sk_rdata;
  assign card_addr_out = r.addr_out;
  assign card_addr_hi_oe = r.hi_oe;
  assign card_addr_lo_oe = r.lo_oe;
  assign video_select_n = r.sel_n;
  assign video_status_out = r.stat;
  assign status_pull_up_en = r.pull_up;
  assign status_pull_down_en = r.pull_dn;

  // Checks on the address, steering and register paths of this block.
  a_legacy_release: assert property (@(posedge clk) disable iff (!resetn)
    (cfg_wr && cfg_addr == `CVP_CFG_CARD_CTRL && cfg_sock == '0 && cfg_wdata[6])
      |=> ##1 !card_addr_hi_oe[0])
    else $error("Legacy enable did not release upper address lines.");

  a_low_driven: assert property (@(posedge clk) disable iff (!resetn)
    card_addr_lo_oe == {NSOCK{1'b1}})
    else $error("Lower address lines not driven.");

  a_select_low: assert property (@(posedge clk) disable iff (!resetn)
    sel_en |=> !video_select_n)
    else $error("Select not low for enabled socket.");

  a_status_high: assert property (@(posedge clk) disable iff (!resetn)
    port_choice |=> video_status_out)
    else $error("Status not high with port choice set.");

  a_idle_pins: assert property (@(posedge clk) disable iff (!resetn)
    (!port_choice && !eff[0]) |=> (!video_status_out && video_select_n))
    else $error("Idle steering pins wrong.");

  // Firmware may read the capability back one or two edges after forcing it.
  a_force_capable: assert property (@(posedge clk) disable iff (!resetn)
    (sk_wr && sk_addr == `CVP_SK_FORCE && sk_sock == '0 && sk_wdata[27])
      ##[1:2] (sk_rd && sk_addr == `CVP_SK_PRESENT && sk_sock == '0) |=> sk_rdata[27])
    else $error("Capability bit not set by force write.");

  a_activity_read: assert property (@(posedge clk) disable iff (!resetn)
    (sk_rd && sk_addr == `CVP_SK_CTRL)
      |=> (sk_rdata[11] == $past(|eff) && sk_rdata[10] == !$past(r.std_model_disable)))
    else $error("Activity or model bit wrong.");

  // With its legacy enable clear, socket one is enabled only through the standardized path, so it shows the gating.
  a_diag_blocks: assert property (@(posedge clk) disable iff (!resetn)
    (r.std_model_disable && !r.legacy_video_enable[1]) |=> card_addr_hi_oe[1])
    else $error("Standardized enable acted while disabled.");

  a_tick_spacing: assert property (@(posedge clk) disable iff (!resetn)
    r.osc_tick |=> !r.osc_tick [*2])
    else $error("Slow tick repeated too soon.");

  // A disabled selected socket must leave the external drivers off.
  a_select_high: assert property (@(posedge clk) disable iff (!resetn)
    !sel_en |=> video_select_n)
    else $error("Select low for a disabled socket.");

  // An enabled selected socket always reports status high.
  a_status_enabled: assert property (@(posedge clk) disable iff (!resetn)
    sel_en |=> video_status_out)
    else $error("Status low for an enabled socket.");

  // The legacy path keeps working whatever the diagnostic bit says.
  a_legacy_wins: assert property (@(posedge clk) disable iff (!resetn)
    r.legacy_video_enable[0] |=> !card_addr_hi_oe[0])
    else $error("Legacy enable ignored.");

  // Any effective enable on the second socket releases its upper lines.
  a_second_release: assert property (@(posedge clk) disable iff (!resetn)
    eff[1] |=> !card_addr_hi_oe[1])
    else $error("Second socket upper lines still driven.");

  // A socket control write reaches the address pins two edges later.
  a_socket_enable: assert property (@(posedge clk) disable iff (!resetn)
    (sk_wr && sk_addr == `CVP_SK_CTRL && sk_sock == 1'h1 && sk_wdata[`CVP_SOCK_EN_BIT]
      && !cfg_wr && !r.std_model_disable) |=> ##1 !card_addr_hi_oe[1])
    else $error("Socket control enable did not release upper lines.");

  // A diagnostic write is stored on the edge that takes it.
  a_diag_write: assert property (@(posedge clk) disable iff (!resetn)
    (cfg_wr && cfg_addr == `CVP_CFG_DIAG)
      |=> r.std_model_disable == $past(cfg_wdata[`CVP_DIAG_DIS_BIT]))
    else $error("Diagnostic bit not stored.");

  // Read-back of the legacy enable for socket zero.
  a_legacy_readback: assert property (@(posedge clk) disable iff (!resetn)
    (cfg_rd && cfg_addr == `CVP_CFG_CARD_CTRL && cfg_sock == '0)
      |=> cfg_rdata[`CVP_LEGACY_EN_BIT] == $past(r.legacy_video_enable[0]))
    else $error("Legacy enable read-back wrong.");

  // Read-back of the socket control enable for socket one.
  a_enable_readback: assert property (@(posedge clk) disable iff (!resetn)
    (sk_rd && sk_addr == `CVP_SK_CTRL && sk_sock == 1'h1)
      |=> sk_rdata[`CVP_SOCK_EN_BIT] == $past(r.socket_video_on[1]))
    else $error("Socket enable read-back wrong.");

  // Only reset clears the capability bit, so firmware sets it once per power-up.
  a_cap_sticky: assert property (@(posedge clk) disable iff (!resetn)
    r.platform_video_capable[0] |=> r.platform_video_capable[0])
    else $error("Capability bit cleared.");

  // Address lines pass through exactly one register stage.
  a_addr_copy: assert property (@(posedge clk) disable iff (!resetn)
    $past(resetn) |-> card_addr_out == $past(host_addr))
    else $error("Card address not a one-cycle copy of the host address.");

  // Pull selection follows the detection result one edge later.
  a_pull_follows: assert property (@(posedge clk) disable iff (!resetn)
    $past(resetn) |-> (status_pull_up_en[0] == $past(det[0].pull_up)
      && status_pull_down_en[1] == $past(det[1].pull_dn)))
    else $error("Status-change pull selection lags detection.");

  // The tick only fires on the cycle the divider wraps.
  a_tick_phase: assert property (@(posedge clk) disable iff (!resetn)
    r.osc_tick |-> r.osc_cnt == 16'h0000)
    else $error("Slow tick out of phase with its divider.");
endmodule

// ---- dv/video_bus_driver.sv ----
`timescale 1ns/1ps
// Three-state bus driver between a card and the graphics controller.
module video_bus_driver (
  // Clock and active-low enable.
  input wire logic clk,
  input wire logic oe_n,
  // Card side and graphics side data.
  input wire logic [21:0] src,
  output logic [21:0] gfx
);
  logic [21:0] last = 22'h0;
  // A released bus keeps no value, so it toggles instead of holding one.
  always_ff @(posedge clk) begin
    last <= gfx;
  end
  assign gfx = oe_n ? ~last : src;
endmodule

// ---- dv/card_video_port_control_test.sv ----
`timescale 1ns/1ps
module card_video_port_control_test;
  logic clk = 0, resetn = 0, cfg_wr = 0, cfg_rd = 0, sk_wr = 0, sk_rd = 0, port_choice = 0;
  logic [0:0] cfg_sock = 0, sk_sock = 0;
  logic [7:0] cfg_addr = 0, cfg_wdata = 0, sk_addr = 0, cfg_rdata;
  logic [31:0] sk_wdata = 0, sk_rdata;
  logic [1:0][25:0] host_addr = '0, card_addr_out;
  logic [1:0] det_one = 2'h3, det_two = 2'h3, sense_one = 2'h3, sense_two = 2'h0, pwr = 2'h0;
  logic [1:0] hi_oe, lo_oe, pu, pd;
  logic vsel_n, vstat, cfg_rd_d = 0, sk_rd_d = 0;
  logic [21:0] vid_src = 22'h0, gfx;
  logic [31:0] exp_q[$], msk_q[$];
  int miscompares = 0, samples_checked = 0, cycles = 0;

  // Slow oscillator divider shortened so detection settles within about ten cycles.
  card_video_port_control #(.NSOCK(2), .OSC_DIV(4)) u_dut (
    .clk(clk), .resetn(resetn), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_sock(cfg_sock),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .sk_wr(sk_wr),
    .sk_rd(sk_rd), .sk_sock(sk_sock), .sk_addr(sk_addr), .sk_wdata(sk_wdata),
    .sk_rdata(sk_rdata), .host_addr(host_addr), .card_addr_out(card_addr_out),
    .card_addr_hi_oe(hi_oe), .card_addr_lo_oe(lo_oe), .port_choice(port_choice),
    .video_select_n(vsel_n), .video_status_out(vstat), .card_detect_one(det_one),
    .card_detect_two(det_two), .volt_sense_one(sense_one), .volt_sense_two(sense_two),
    .socket_powered(pwr), .status_pull_up_en(pu), .status_pull_down_en(pd));

  // The card drives the upper lines itself once the controller lets go of them.
  video_bus_driver u_drv (.clk(clk), .oe_n(vsel_n),
    .src(hi_oe[0] ? card_addr_out[0][25:4] : vid_src), .gfx(gfx));

  always #4 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One register access; a read leaves its masked expectation in the queue.
  task automatic acc(input bit sk, input bit wr, input logic [0:0] s, input logic [7:0] a,
    input logic [31:0] d, input logic [31:0] m);
    @(negedge clk);
    if (!wr) begin
      exp_q.push_back(d & m);
      msk_q.push_back(m);
    end
    {cfg_sock, sk_sock, cfg_addr, sk_addr, cfg_wdata, sk_wdata} = {s, s, a, a, d[7:0], d};
    {cfg_wr, cfg_rd, sk_wr, sk_rd} = {wr & !sk, !wr & !sk, wr & sk, !wr & sk};
    @(negedge clk);
    {cfg_wr, cfg_rd, sk_wr, sk_rd} = 4'h0;
  endtask

  // Read data stands for one cycle after the read edge, so it is taken then.
  always @(posedge clk) begin
    cfg_rd_d <= cfg_rd;
    sk_rd_d <= sk_rd;
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      final_report();
    end
  end

  always @(negedge clk) begin
    if (cfg_rd_d | sk_rd_d) begin
      chk("read_data", exp_q.pop_front(),
        (cfg_rd_d ? {24'h0, cfg_rdata} : sk_rdata) & msk_q.pop_front());
    end
  end

  initial begin
    void'($urandom(31558));
    repeat (20) @(negedge clk);
    resetn = 1;
    @(negedge clk);
    chk("video_select_n", 32'h1, vsel_n);
    chk("video_status_out", 32'h0, vstat);
    host_addr = 52'({$urandom(), $urandom()});
    vid_src = 22'($urandom());
    repeat (2) @(negedge clk);
    chk("card_addr_out", host_addr[0], card_addr_out[0]);
    chk("card_addr_hi_oe", 32'h3, hi_oe);
    acc(0, 1, 0, 8'h91, 32'h40, 0);
    repeat (3) @(negedge clk);
    chk("card_addr_hi_oe", 32'h2, hi_oe);
    chk("card_addr_lo_oe", 32'h3, lo_oe);
    chk("video_select_n", 32'h0, vsel_n);
    chk("video_status_out", 32'h1, vstat);
    chk("gfx_data", vid_src, gfx);
    acc(0, 0, 0, 8'h91, 32'h40, 32'h40);
    acc(1, 0, 1, 8'h10, 32'hC00, 32'hE00);
    port_choice = 1;
    repeat (2) @(negedge clk);
    chk("video_select_n", 32'h1, vsel_n);
    chk("video_status_out", 32'h1, vstat);
    acc(1, 1, 1, 8'h10, 32'h200, 0);
    repeat (3) @(negedge clk);
    chk("video_select_n", 32'h0, vsel_n);
    chk("card_addr_hi_oe", 32'h0, hi_oe);
    acc(0, 1, 0, 8'h93, 32'h1, 0);
    repeat (3) @(negedge clk);
    chk("video_select_n", 32'h1, vsel_n);
    chk("card_addr_hi_oe", 32'h2, hi_oe);
    acc(0, 1, 0, 8'h93, 32'h0, 0);
    acc(0, 1, 0, 8'h91, 32'h0, 0);
    acc(1, 1, 1, 8'h10, 32'h0, 0);
    port_choice = 0;
    repeat (3) @(negedge clk);
    chk("video_select_n", 32'h1, vsel_n);
    chk("video_status_out", 32'h0, vstat);
    chk("card_addr_hi_oe", 32'h3, hi_oe);
    acc(1, 0, 0, 8'h10, 32'h400, 32'hE00);
    acc(1, 0, 0, 8'h08, 32'h0, 32'h0800_0000);
    acc(1, 1, 0, 8'h0C, 32'h0800_0000, 0);
    acc(1, 0, 0, 8'h08, 32'h0800_0000, 32'h0800_0000);
    acc(1, 0, 1, 8'h08, 32'h0, 32'h0800_0000);
    acc(1, 0, 0, 8'h0C, 32'h0, 32'hFFFF_FFFF);
    acc(1, 0, 0, 8'h40, 32'h0, 32'hFFFF_FFFF);
    // Socket zero gets a 16-bit card, socket one a CardBus card.
    det_one = 2'h0;
    det_two = 2'h2;
    repeat (40) @(negedge clk);
    chk("status_pull_up_en", 32'h1, pu);
    chk("status_pull_down_en", 32'h2, pd);
    acc(1, 0, 1, 8'h08, 32'h70, 32'hF0);
    // Pulling both cards must drop the pull selection and the detection result.
    det_one = 2'h3;
    det_two = 2'h3;
    repeat (4) @(negedge clk);
    chk("status_pull_up_en", 32'h0, pu);
    chk("status_pull_down_en", 32'h0, pd);
    acc(1, 0, 1, 8'h08, 32'h0, 32'hF0);
    // A powered socket must never be interrogated.
    pwr = 2'h3;
    det_one = 2'h0;
    det_two = 2'h0;
    repeat (20) @(negedge clk);
    chk("status_pull_up_en", 32'h0, pu);
    repeat (4) @(negedge clk);
    final_report();
  end
endmodule
